// ===== src/adccfg_defs.vh
// adccfg_defs.vh: offsets, field positions, reset values and codes of the
// converter configuration block.
// assumes a 32-bit apb master with word-aligned byte addresses.
`ifndef ADCCFG_DEFS_VH
`define ADCCFG_DEFS_VH

// ==========================================================
// register map (byte addresses)
`define ADCCFG_CTRL1_OFF 12'h000
`define ADCCFG_TRIG_OFF 12'h004
`define ADCCFG_STATUS_OFF 12'h008
`define ADCCFG_ENABLE_OFF 12'h00c
`define ADCCFG_RESULT_OFF 12'h010

// ==========================================================
// field positions of converter_control_one
`define ADCCFG_FMT_BIT 7
`define ADCCFG_CS_MSB 6
`define ADCCFG_CS_LSB 4
`define ADCCFG_NREF_BIT 2
`define ADCCFG_PREF_MSB 1
`define ADCCFG_PREF_LSB 0
`define ADCCFG_CTRL1_MASK 8'hf7
`define ADCCFG_TRIG_MASK 8'h1f

// ==========================================================
// reset values
`define ADCCFG_CTRL1_RST 8'h00
`define ADCCFG_TRIG_RST 8'h00

// ==========================================================
// conversion clock select codes
`define ADCCFG_CS_DIV2 3'h0
`define ADCCFG_CS_DIV8 3'h1
`define ADCCFG_CS_DIV32 3'h2
`define ADCCFG_CS_RC_A 3'h3
`define ADCCFG_CS_DIV4 3'h4
`define ADCCFG_CS_DIV16 3'h5
`define ADCCFG_CS_DIV64 3'h6
`define ADCCFG_CS_RC_B 3'h7

// divider half-period counts minus one, per clock select code
`define ADCCFG_HALF_DIV2 6'h00
`define ADCCFG_HALF_DIV4 6'h01
`define ADCCFG_HALF_DIV8 6'h03
`define ADCCFG_HALF_DIV16 6'h07
`define ADCCFG_HALF_DIV32 6'h0f
`define ADCCFG_HALF_DIV64 6'h1f

// positive reference codes
`define ADCCFG_PREF_VDD 2'h0
`define ADCCFG_PREF_RSV 2'h1
`define ADCCFG_PREF_EXT 2'h2
`define ADCCFG_PREF_FIXED 2'h3

// trigger source count: codes 1..17 select sources
`define ADCCFG_TRIG_NUM 17
`define ADCCFG_TRIG_OFF_CODE 5'h00
`define ADCCFG_TRIG_MAX_CODE 5'h11

`endif

// ===== src/adccfg_top.v
// adccfg_top.v: configuration and auto-trigger select of the converter.
// holds the two control registers, the divided conversion clock, the
// reference routing, the hardware start pulse and the justified result.
// assumes an apb master on pclk, peripheral interrupt flags and the raw
// 10-bit result synchronous to pclk.
// assumes the rc conversion clock itself lives outside this block; only its
// select is given out here.
//
// Overview of operation
// R01: with the format bit set the result is right-justified, six unused bits zero.
// R02: the clock select gives osc/2,/8,/32,/4,/16,/64, and 011 or 111 pick the RC clock.
// R03: the negative reference select routes low reference to ground at 0, to the pin at 1.
// R04: while the converter is disabled every multiplexer input is disconnected.
// R05: positive reference code 00 gives supply, 10 the pin, 11 the fixed reference, 01 reserved.
// R06: trigger code 0 disables hardware start; codes 1 to 17 select one event source.
// R07: a selected source counts as asserted when its interrupt flag becomes set.
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "adccfg_defs.vh"

module adccfg_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire [16:0] trigger_flags,
    input wire result_load,
    input wire [9:0] result_raw,
    output reg conv_clk,
    output wire conv_clk_rc_sel,
    output wire vref_neg_gnd,
    output wire vref_neg_pin,
    output wire vref_pos_vdd,
    output wire vref_pos_pin,
    output wire vref_pos_fixed,
    output wire mux_connect,
    output reg auto_trigger,
    output reg [7:0] result_high_byte,
    output reg [7:0] result_low_byte
);

    reg [7:0] ctrl1_reg;
    reg [7:0] trig_reg;
    reg converter_enable_bit_reg;
    reg [16:0] flags_dly_reg;
    reg [5:0] div_cnt_reg;
    reg [5:0] div_half;
    reg trig_seen_reg;
    reg [31:0] rd_mux;
    wire result_format_select;
    wire [2:0] conv_clock_select;
    wire neg_ref_select;
    wire [1:0] pos_ref_select;
    wire [4:0] auto_trigger_source;
    wire wr_en;
    wire wr_ctrl1;
    wire wr_trig;
    wire wr_enable;
    wire rd_setup;
    wire rd_status_done;
    wire [16:0] flag_rise;
    wire sel_rise;

    assign result_format_select = ctrl1_reg[`ADCCFG_FMT_BIT];
    assign conv_clock_select = ctrl1_reg[`ADCCFG_CS_MSB:`ADCCFG_CS_LSB];
    assign neg_ref_select = ctrl1_reg[`ADCCFG_NREF_BIT];
    assign pos_ref_select = ctrl1_reg[`ADCCFG_PREF_MSB:`ADCCFG_PREF_LSB];
    assign auto_trigger_source = trig_reg[4:0];

    // =======================================================
    // apb slave: zero wait states, unmapped reads give zero
    // every access completes in its first access cycle, so pready is a constant
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign pslverr = psel & penable & (paddr[1:0] != 2'h0 || paddr > `ADCCFG_RESULT_OFF);

    // per-register strobes; status and result are read-only, so writes there drop
    assign wr_ctrl1 = wr_en & (paddr == `ADCCFG_CTRL1_OFF);
    assign wr_trig = wr_en & (paddr == `ADCCFG_TRIG_OFF);
    assign wr_enable = wr_en & (paddr == `ADCCFG_ENABLE_OFF);
    // reads are captured in the setup cycle and retired in the access cycle
    assign rd_setup = psel & ~penable & ~pwrite;
    assign rd_status_done = psel & penable & ~pwrite & (paddr == `ADCCFG_STATUS_OFF);

    // register writes; unimplemented bits are dropped so they read as zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1_reg <= `ADCCFG_CTRL1_RST;
            trig_reg <= `ADCCFG_TRIG_RST;
            converter_enable_bit_reg <= 1'b0;
        end else begin
            if (wr_ctrl1)
                ctrl1_reg <= pwdata[7:0] & `ADCCFG_CTRL1_MASK;
            if (wr_trig)
                trig_reg <= pwdata[7:0] & `ADCCFG_TRIG_MASK;
            if (wr_enable)
                converter_enable_bit_reg <= pwdata[0];
        end
    end

    // read mux; status shows trigger seen since last read
    always @* begin
        case (paddr)
            `ADCCFG_CTRL1_OFF: rd_mux = {24'h000000, ctrl1_reg};
            `ADCCFG_TRIG_OFF: rd_mux = {24'h000000, trig_reg};
            `ADCCFG_STATUS_OFF: rd_mux = {30'h0, trig_seen_reg, conv_clk_rc_sel};
            `ADCCFG_ENABLE_OFF: rd_mux = {31'h0, converter_enable_bit_reg};
            `ADCCFG_RESULT_OFF: rd_mux = {16'h0000, result_high_byte, result_low_byte};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // read data register: loaded in the setup cycle, so the access cycle shows
    // a flip-flop; apb holds paddr across both cycles, so no wait state is paid.
    // a value that changes between setup and access is reported on the next read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= rd_mux;
        end
    end

    // =======================================================
    // R02: clock divider select
    assign conv_clk_rc_sel = (conv_clock_select == `ADCCFG_CS_RC_A) ||
                             (conv_clock_select == `ADCCFG_CS_RC_B);

    // half-period minus one for each divide ratio
    // the rc codes fall to the default; the divider is parked for them anyway
    always @* begin
        case (conv_clock_select)
            `ADCCFG_CS_DIV2: div_half = `ADCCFG_HALF_DIV2;
            `ADCCFG_CS_DIV8: div_half = `ADCCFG_HALF_DIV8;
            `ADCCFG_CS_DIV32: div_half = `ADCCFG_HALF_DIV32;
            `ADCCFG_CS_DIV4: div_half = `ADCCFG_HALF_DIV4;
            `ADCCFG_CS_DIV16: div_half = `ADCCFG_HALF_DIV16;
            `ADCCFG_CS_DIV64: div_half = `ADCCFG_HALF_DIV64;
            default: div_half = `ADCCFG_HALF_DIV2;
        endcase
    end

    // a select change mid-period is taken at once: the >= compare stops a count
    // that is already past the new end from wrapping through all 64 steps
    // R02: divided clock; held low when RC is chosen, since that clock lives outside
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= 6'h00;
            conv_clk <= 1'b0;
        end else if (conv_clk_rc_sel) begin
            div_cnt_reg <= 6'h00;
            conv_clk <= 1'b0;
        end else if (div_cnt_reg >= div_half) begin
            div_cnt_reg <= 6'h00;
            conv_clk <= ~conv_clk;
        end else begin
            div_cnt_reg <= div_cnt_reg + 6'h01;
        end
    end

    // =======================================================
    // the routing is purely combinational, so a reference change reaches the
    // analog switches in the cycle right after its write
    // R04: enable gates every reference connection
    assign mux_connect = converter_enable_bit_reg;
    // R03: negative reference route
    assign vref_neg_gnd = converter_enable_bit_reg & ~neg_ref_select;
    assign vref_neg_pin = converter_enable_bit_reg & neg_ref_select;
    // R05: positive reference route, reserved code connects nothing
    assign vref_pos_vdd = converter_enable_bit_reg & (pos_ref_select == `ADCCFG_PREF_VDD);
    assign vref_pos_pin = converter_enable_bit_reg & (pos_ref_select == `ADCCFG_PREF_EXT);
    assign vref_pos_fixed = converter_enable_bit_reg & (pos_ref_select == `ADCCFG_PREF_FIXED);

    // =======================================================
    // the delay flops reset low like the idle flags, so no false edge follows
    // reset while the peripherals sit idle
    // R07: rising edge of each peripheral interrupt flag
    assign flag_rise = trigger_flags & ~flags_dly_reg;
    // R06: code zero or out of range selects nothing
    // codes 18 to 31 fail the range check, which also keeps the index in range
    assign sel_rise = (auto_trigger_source != `ADCCFG_TRIG_OFF_CODE) &&
                      (auto_trigger_source <= `ADCCFG_TRIG_MAX_CODE) &&
                      flag_rise[auto_trigger_source - 5'h01];

    // one-cycle start pulse; sticky seen bit clears on status read, set wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_dly_reg <= 17'h00000;
            auto_trigger <= 1'b0;
            trig_seen_reg <= 1'b0;
        end else begin
            flags_dly_reg <= trigger_flags;
            auto_trigger <= sel_rise;
            // R07: a new event wins over a clear in the same cycle
            if (sel_rise)
                trig_seen_reg <= 1'b1;
            // clear only what the setup cycle captured, so an event that lands
            // between setup and access survives for the next read
            else if (rd_status_done && prdata[1])
                trig_seen_reg <= 1'b0;
        end
    end

    // =======================================================
    // the raw result is taken as settled in the cycle of result_load; the bytes
    // keep their old value until the next load
    // R01: result justification on load
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_high_byte <= 8'h00;
            result_low_byte <= 8'h00;
        end else if (result_load) begin
            if (result_format_select) begin
                result_high_byte <= {6'h00, result_raw[9:8]};
                result_low_byte <= result_raw[7:0];
            end else begin
                result_high_byte <= result_raw[9:2];
                result_low_byte <= {result_raw[1:0], 6'h00};
            end
        end
    end

endmodule

// ===== testbench/adccfg_chk.sv
// adccfg_chk.sv: port-level assertions for the converter configuration block.
// assumes only the top module ports; bound by name below.
`timescale 1ns/1ps
// ==========================================================
// checker
module adccfg_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire pready,
    input wire [16:0] trigger_flags,
    input wire result_load,
    input wire conv_clk,
    input wire conv_clk_rc_sel,
    input wire vref_neg_gnd,
    input wire vref_neg_pin,
    input wire vref_pos_vdd,
    input wire vref_pos_pin,
    input wire vref_pos_fixed,
    input wire mux_connect,
    input wire auto_trigger,
    input wire [7:0] result_high_byte,
    input wire [7:0] result_low_byte
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // one of the two justifications always leaves six zero bits
    a_result_zero_pad: assert property (result_load |=>
        (result_high_byte[7:2] == 6'h00 || result_low_byte[5:0] == 6'h00))
        else $error("result bytes lack zero padding");
    a_rc_clock_quiet: assert property (conv_clk_rc_sel [*3] |-> !conv_clk)
        else $error("divided clock runs while rc clock selected");
    a_neg_ref_one: assert property (mux_connect |-> vref_neg_gnd != vref_neg_pin)
        else $error("negative reference not exactly one source");
    a_mux_off_all: assert property (!mux_connect |->
        !(vref_neg_gnd | vref_neg_pin | vref_pos_vdd | vref_pos_pin | vref_pos_fixed))
        else $error("reference connected while converter disabled");
    a_pos_ref_one: assert property ($onehot0({vref_pos_vdd, vref_pos_pin, vref_pos_fixed}))
        else $error("two positive references at once");
    a_trig_cause: assert property (auto_trigger |->
        |($past(trigger_flags) & ~$past(trigger_flags, 2)))
        else $error("trigger without a rising flag");
    a_trig_pulse: assert property (auto_trigger |=> !auto_trigger)
        else $error("trigger pulse longer than one cycle");
    a_bus_ready: assert property (psel |-> pready)
        else $error("bus access not completed");
    c_trig: cover property (auto_trigger);
    c_fixed: cover property (mux_connect && vref_pos_fixed);
    c_load: cover property (result_load);
endmodule

bind adccfg_top adccfg_chk adccfg_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .pready(pready), .trigger_flags(trigger_flags), .result_load(result_load),
    .conv_clk(conv_clk), .conv_clk_rc_sel(conv_clk_rc_sel), .vref_neg_gnd(vref_neg_gnd),
    .vref_neg_pin(vref_neg_pin), .vref_pos_vdd(vref_pos_vdd), .vref_pos_pin(vref_pos_pin),
    .vref_pos_fixed(vref_pos_fixed), .mux_connect(mux_connect),
    .auto_trigger(auto_trigger), .result_high_byte(result_high_byte),
    .result_low_byte(result_low_byte));

// ===== testbench/testbench.sv
// testbench.sv: directed scenarios for the converter configuration block.
// assumes the apb slave answers at once; checker bound separately.
`timescale 1ns/1ps
module testbench;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, result_load = 0, slv;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, rd;
    reg [16:0] trigger_flags = 0;
    reg [9:0] result_raw = 0;
    wire pready, pslverr, conv_clk, rc, ng, np, pv, pp, pf, mx, at;
    wire [31:0] prdata;
    wire [7:0] rh, rl;
    integer err_total = 0, tests_run = 0, i;
    integer dv [0:7] = '{2, 8, 32, 0, 4, 16, 64, 0};
    real t0;
    adccfg_top adccfg_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .trigger_flags(trigger_flags),
        .result_load(result_load), .result_raw(result_raw), .conv_clk(conv_clk),
        .conv_clk_rc_sel(rc), .vref_neg_gnd(ng), .vref_neg_pin(np), .vref_pos_vdd(pv),
        .vref_pos_pin(pp), .vref_pos_fixed(pf), .mux_connect(mx), .auto_trigger(at),
        .result_high_byte(rh), .result_low_byte(rl));
    // ==========================================================
    // shared tasks
    task chk(input [31:0] s, input [31:0] e);
        tests_run = tests_run + 1;
        if (s !== e) begin
            err_total = err_total + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // setup, then access held until pready is sampled high
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        slv = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task t_regs;
        apb(0, 12'h000, 0); chk(rd, 32'h00);
        apb(0, 12'h004, 0); chk(rd, 32'h00);
        apb(1, 12'h000, 32'hff); apb(0, 12'h000, 0); chk(rd, 32'hf7);
        apb(1, 12'h004, 32'hff); apb(0, 12'h004, 0); chk(rd, 32'h1f);
        chk(slv, 0);
        apb(0, 12'h00c, 0);
        chk(rd, 32'h00);
        apb(0, 12'h008, 0);
        chk(rd, 32'h01);
        apb(0, 12'h014, 0);
        chk(rd, 32'h00);
        chk(slv, 1);
    endtask
    // each select either divides pclk or parks the clock for the rc source
    task t_clk;
        for (i = 0; i < 8; i = i + 1) begin
            apb(1, 12'h000, i << 4);
            repeat (8) @(posedge pclk);
            #1 chk(rc, dv[i] == 0);
            if (dv[i] == 0) chk(conv_clk, 0);
            else begin
                @(posedge conv_clk) t0 = $realtime;
                @(posedge conv_clk) chk(($realtime - t0) / 20, dv[i]);
            end
        end
    endtask
    task t_ref;
        for (i = 0; i < 16; i = i + 1) begin
            apb(1, 12'h00c, i >> 3);
            apb(1, 12'h000, i & 7);
            #1 chk({ng, np, pv, pp, pf, mx}, i < 8 ? 6'h00 : {!i[2], i[2], i[1:0] == 0,
                i[1:0] == 2, i[1:0] == 3, 1'b1});
        end
    endtask
    // foreign flags first, then the selected one; code 0 never fires
    task t_trig;
        for (i = 0; i < 18; i = i + 1) begin
            apb(1, 12'h004, i);
            @(posedge pclk) trigger_flags <= ~(i ? 17'h1 << (i - 1) : 17'h0);
            @(posedge pclk) #1 chk(at, 0);
            @(posedge pclk) trigger_flags <= 17'h1ffff;
            @(posedge pclk) #1 chk(at, i != 0);
            @(posedge pclk) #1 chk(at, 0);
            @(posedge pclk) trigger_flags <= 0;
        end
        apb(0, 12'h008, 0);
        chk(rd, 32'h02);
        apb(0, 12'h008, 0);
        chk(rd, 32'h00);
    endtask
    task t_res;
        for (i = 0; i < 2; i = i + 1) begin
            apb(1, 12'h000, i << 7);
            @(posedge pclk) result_load <= 1;
            result_raw <= 10'h2c5;
            @(posedge pclk) result_load <= 0;
            #1 chk({rh, rl}, i ? 16'h02c5 : 16'hb140);
            apb(0, 12'h010, 0); chk(rd, i ? 32'h02c5 : 32'hb140);
        end
    endtask
    // ==========================================================
    // clock, watchdog and main sequence
    initial forever #10 pclk = ~pclk;
    initial begin
        #200000;
        err_total = err_total + 1;
        summarize;
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        t_regs; t_clk; t_ref; t_trig; t_res;
        summarize;
    end
endmodule
